// ===== src/atg_pkg.sv
// Purpose: shared constants for the system-board glue
// Assumes: 24-bit memory address, 10-bit i/o address
// Notes:   page registers addressed by the full 10-bit i/o port
package atg_pkg;
	// i/o space split
	localparam logic [9:0]  IO_BOARD_LAST   = 10'h0FF;
	localparam logic [9:0]  IO_CHAN_FIRST   = 10'h100;
	localparam logic [9:0]  IO_CHAN_LAST    = 10'h3FF;
	localparam logic [9:0]  IO_TIMER_BASE   = 10'h040;
	localparam logic [9:0]  IO_TIMER_MASK   = 10'h3FC;
	localparam logic [9:0]  IO_SYS_CTRL     = 10'h061;
	localparam logic [9:0]  IO_FPU_CLR_BUSY = 10'h0F0;
	// dma page register ports
	localparam logic [9:0]  PG_CH0          = 10'h087;
	localparam logic [9:0]  PG_CH1          = 10'h083;
	localparam logic [9:0]  PG_CH2          = 10'h081;
	localparam logic [9:0]  PG_CH3          = 10'h082;
	localparam logic [9:0]  PG_CH5          = 10'h08B;
	localparam logic [9:0]  PG_CH6          = 10'h089;
	localparam logic [9:0]  PG_CH7          = 10'h08A;
	localparam logic [9:0]  PG_REFRESH      = 10'h08F;
	localparam logic [7:0]  PAGE_RESET      = 8'h00;
	// page slot indices (slot 4 is refresh since channel 4 is cascade)
	localparam int          PG_SLOTS        = 8;
	localparam logic [2:0]  SLOT_REFRESH    = 3'h4;
	localparam logic [2:0]  DMA_CASCADE_CH  = 3'h4;
	// memory regions
	localparam logic [23:0] MEM_ADROM_LO    = 24'h0C0000;
	localparam logic [23:0] MEM_ADROM_HI    = 24'h0DFFFF;
	localparam logic [23:0] MEM_SYSROM_LO   = 24'h0E0000;
	localparam logic [23:0] MEM_SYSROM_HI   = 24'h0EFFFF;
	// system control port fields
	localparam int          SC_GATE2_BIT    = 0;
	localparam logic [7:0]  SC_RESET        = 8'h00;
	// access width
	typedef enum logic [1:0] {
		ATG_CYC_IDLE = 2'b00,
		ATG_CYC_8    = 2'b01,
		ATG_CYC_16   = 2'b10
	} atg_cyc_t;
endpackage

// ===== src/atg_board_glue.sv
// Purpose: address decode, timer/interrupt/dma wiring and page registers
// Assumes: i/o strobes are single-cycle, synchronous to i_clk_sys
// Notes:   timer, interrupt and dma controllers sit outside; this is glue
module atg_board_glue (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	// processor i/o port
	input  wire logic [9:0]  i_io_addr,
	input  wire logic        i_io_wr,
	input  wire logic        i_io_rd,
	input  wire logic [7:0]  i_io_wdata,
	output logic [7:0]       o_io_rdata,
	output logic             o_io_rvalid,
	// processor memory port
	input  wire logic [23:0] i_mem_addr,
	input  wire logic        i_mem_req,
	input  wire logic        i_shadow_adrom,
	input  wire logic        i_shadow_sysrom,
	// decode results
	output logic             o_io_board_sel,
	output logic             o_io_chan_fwd,
	output logic             o_timer_sel,
	output logic [1:0]       o_timer_port,
	output logic             o_mem_shadow_sel,
	output logic             o_mem_chan_fwd,
	output logic [23:0]      o_chan_addr,
	// expansion channel sizing
	input  wire logic        i_card_cs16_n,
	output logic             o_cycle_16,
	output logic             o_cycle_8,
	// timer wiring
	input  wire logic        i_timer_out0,
	input  wire logic        i_timer_out1,
	input  wire logic        i_timer_out2,
	output logic             o_timer_gate0,
	output logic             o_timer_gate1,
	output logic             o_timer_gate2,
	output logic             o_refresh_req,
	output logic             o_speaker,
	// interrupts
	input  wire logic        i_sec_int,
	input  wire logic [7:0]  i_irq_pri,
	output logic [7:0]       o_pri_irq,
	output logic [2:0]       o_irq_top,
	output logic             o_irq_any,
	input  wire logic        i_parity_err,
	input  wire logic        i_chan_check_n,
	output logic             o_nmi,
	// coprocessor busy
	input  wire logic        i_fpu_busy_set,
	output logic             o_fpu_busy,
	// dma
	input  wire logic [2:0]  i_dma_ch,
	input  wire logic        i_dma_active,
	input  wire logic        i_refresh_cycle,
	output logic [7:0]       o_dma_page,
	output logic             o_dma_word,
	output logic             o_dma_ch_valid
);

	logic [7:0] page_reg [atg_pkg::PG_SLOTS];
	logic [7:0] sys_ctrl_reg;
	logic       fpu_busy_reg;
	logic       refresh_prev_reg;
	logic [7:0] io_rdata_reg;
	logic       io_rvalid_reg;
	logic [2:0] page_slot;
	logic       page_hit;
	logic       in_adrom;
	logic       in_sysrom;
	logic [9:0] pg_addr [atg_pkg::PG_SLOTS];

	// block overview
	// the glue sits between the processor bus and the board peripherals
	// it owns a few registers: eight page bytes, the control byte
	// at port 061, the coprocessor busy latch, the refresh edge flop
	// and the readback byte and valid; everything else is combinational wiring and decode
	//
	// i/o decode
	// the low quarter of the 10-bit i/o space belongs to the board
	// anything above it goes out on the expansion channel
	// the two selects are mutually exclusive by construction
	// a strobe is needed for either select to rise
	//
	// timer
	// the timer itself lives outside; this block picks its ports, drives its gates
	// and takes its outputs to irq 0, refresh and speaker; counters 0 and 1 run free
	// counter 2 is started and stopped by software through port 061
	//
	// page registers
	// slot index follows the dma channel number, except slot 4
	// channel 4 is the cascade link and has no page of its own,
	// so its slot is reused for the refresh page
	// a write to a page port lands on the next edge
	// a read returns the byte one cycle later with a valid pulse
	//
	// hazards
	// the coprocessor busy latch can see a set and a clear together;
	// the set wins so a fresh busy is never lost
	// the refresh edge detector resets low, so a timer output that is
	// already high at reset release gives one request straight away
	//
	// interrupts
	// only the primary request lines and a lowest-index priority pick
	// are formed here; the controllers themselves sit outside
	// the secondary controller rides in through line 2
	//
	// memory decode
	// the two rom windows can each be shadowed in board ram
	// adapter rom that is not shadowed is forwarded to the channel
	// system rom that is not shadowed stays on the board

	// page port table, indexed by slot
	assign pg_addr[0] = atg_pkg::PG_CH0;
	assign pg_addr[1] = atg_pkg::PG_CH1;
	assign pg_addr[2] = atg_pkg::PG_CH2;
	assign pg_addr[3] = atg_pkg::PG_CH3;
	assign pg_addr[4] = atg_pkg::PG_REFRESH;
	assign pg_addr[5] = atg_pkg::PG_CH5;
	assign pg_addr[6] = atg_pkg::PG_CH6;
	assign pg_addr[7] = atg_pkg::PG_CH7;

	// i/o space split
	assign o_io_board_sel = (i_io_rd | i_io_wr) && (i_io_addr <= atg_pkg::IO_BOARD_LAST);
	assign o_io_chan_fwd  = (i_io_rd | i_io_wr) && (i_io_addr >= atg_pkg::IO_CHAN_FIRST)
		&& (i_io_addr <= atg_pkg::IO_CHAN_LAST);
	// timer: four ports, low two bits pick counter 0-2 or control
	assign o_timer_sel  = o_io_board_sel && ((i_io_addr & atg_pkg::IO_TIMER_MASK) == atg_pkg::IO_TIMER_BASE);
	assign o_timer_port = i_io_addr[1:0];

	// page register address match
	always_comb begin
		page_hit  = 1'b0;
		page_slot = 3'h0;
		for (int k = 0; k < atg_pkg::PG_SLOTS; k++) begin
			if (i_io_addr == pg_addr[k]) begin
				page_hit  = 1'b1;
				page_slot = 3'(k);
			end
		end
	end

	// page register storage, one per slot
	genvar g;
	generate
		for (g = 0; g < atg_pkg::PG_SLOTS; g++) begin : g_page
			always_ff @(posedge i_clk_sys) begin
				if (i_rst) begin
					page_reg[g] <= atg_pkg::PAGE_RESET;
				end else if (i_io_wr && page_hit && page_slot == 3'(g)) begin
					page_reg[g] <= i_io_wdata;
				end
			end
		end
	endgenerate

	// system control port
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			sys_ctrl_reg <= atg_pkg::SC_RESET;
		end else if (i_io_wr && i_io_addr == atg_pkg::IO_SYS_CTRL) begin
			sys_ctrl_reg <= i_io_wdata;
		end
	end

	// coprocessor busy latch; a new busy wins over the clear
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			fpu_busy_reg <= 1'b0;
		end else if (i_fpu_busy_set) begin
			fpu_busy_reg <= 1'b1;
		end else if (i_io_wr && i_io_addr == atg_pkg::IO_FPU_CLR_BUSY) begin
			fpu_busy_reg <= 1'b0;
		end
	end
	assign o_fpu_busy = fpu_busy_reg;

	// readback of page and control registers, one cycle after the read
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			io_rdata_reg  <= 8'h00;
			io_rvalid_reg <= 1'b0;
		end else begin
			io_rvalid_reg <= i_io_rd && (page_hit || i_io_addr == atg_pkg::IO_SYS_CTRL);
			if (i_io_rd && page_hit) begin
				io_rdata_reg <= page_reg[page_slot];
			end else if (i_io_rd && i_io_addr == atg_pkg::IO_SYS_CTRL) begin
				io_rdata_reg <= sys_ctrl_reg;
			end else if (i_io_rd) begin
				io_rdata_reg <= 8'h00;
			end
		end
	end
	assign o_io_rdata  = io_rdata_reg;
	assign o_io_rvalid = io_rvalid_reg;

	// timer gates and outputs
	assign o_timer_gate0 = 1'b1;
	assign o_timer_gate1 = 1'b1;
	assign o_timer_gate2 = sys_ctrl_reg[atg_pkg::SC_GATE2_BIT];
	assign o_speaker     = i_timer_out2;

	// refresh request on each rising edge of channel 1 output
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			refresh_prev_reg <= 1'b0;
		end else begin
			refresh_prev_reg <= i_timer_out1;
		end
	end
	assign o_refresh_req = i_timer_out1 & ~refresh_prev_reg;

	// primary controller inputs: timer on 0, cascade on 2
	always_comb begin
		o_pri_irq    = i_irq_pri;
		o_pri_irq[0] = i_timer_out0;
		o_pri_irq[2] = i_sec_int;
	end

	// fixed priority: lowest index first, irq2 carries secondary levels
	always_comb begin
		o_irq_top = 3'h0;
		o_irq_any = 1'b0;
		for (int k = 7; k >= 0; k--) begin
			if (o_pri_irq[k]) begin
				o_irq_top = 3'(k);
				o_irq_any = 1'b1;
			end
		end
	end

	// nmi ranks above all maskable sources
	assign o_nmi = i_parity_err | ~i_chan_check_n;

	// memory region decode
	assign in_adrom  = (i_mem_addr >= atg_pkg::MEM_ADROM_LO) && (i_mem_addr <= atg_pkg::MEM_ADROM_HI);
	assign in_sysrom = (i_mem_addr >= atg_pkg::MEM_SYSROM_LO) && (i_mem_addr <= atg_pkg::MEM_SYSROM_HI);
	assign o_mem_shadow_sel = i_mem_req && ((in_adrom && i_shadow_adrom)
		|| (in_sysrom && i_shadow_sysrom));
	assign o_mem_chan_fwd   = i_mem_req && in_adrom && !i_shadow_adrom;
	assign o_chan_addr      = i_mem_addr;

	// cycle sizing from card width
	assign o_cycle_16 = (o_io_chan_fwd || o_mem_chan_fwd) && !i_card_cs16_n;
	assign o_cycle_8  = (o_io_chan_fwd || o_mem_chan_fwd) && i_card_cs16_n;

	// dma channel page and width
	always_comb begin
		o_dma_ch_valid = i_dma_active && (i_dma_ch != atg_pkg::DMA_CASCADE_CH);
		o_dma_word     = o_dma_ch_valid && i_dma_ch[2];
		if (i_refresh_cycle) begin
			o_dma_page = page_reg[atg_pkg::SLOT_REFRESH];
		end else if (o_dma_ch_valid) begin
			o_dma_page = page_reg[i_dma_ch];
		end else begin
			o_dma_page = atg_pkg::PAGE_RESET;
		end
	end

	// dma notes
	// the page byte supplies the address bits above the controller's own
	// word channels 5-7 shift their address by one on the board side;
	// that shift is done outside, the page byte is passed as stored
	// a refresh cycle always takes the refresh page, whatever channel
	// number happens to sit on the channel lines at that time
	// an idle or cascade channel shows a zero page so that stale
	// high bits never reach the address bus
	//
	// sizing notes
	// the card's width signal is only looked at during a forward;
	// board cycles are never sized here
	// the width signal is active low, an absent card reads as 8-bit
	//
	// limits
	// no wait states are inserted by this block
	// the i/o strobes are taken as one cycle long; a longer strobe
	// writes the same byte again, which is harmless for these registers
	// reads of ports that hold no register give no valid pulse
	// and return a zero byte

endmodule

// ===== test/atg_board_checker.sv
// Purpose: port assertions for the board glue
// Assumes: one clock, sync reset high
// Notes:   attached by bind below
module atg_board_checker (
	// clock and reset
	input wire logic       i_clk_sys,
	input wire logic       i_rst,
	// i/o port
	input wire logic [9:0] i_io_addr,
	input wire logic       i_io_wr,
	input wire logic       i_io_rd,
	input wire logic [7:0] i_io_wdata,
	input wire logic       o_io_board_sel,
	input wire logic       o_io_chan_fwd,
	// timer, nmi, dma, coprocessor
	input wire logic       i_timer_out1,
	input wire logic       i_timer_out2,
	input wire logic       o_timer_gate2,
	input wire logic       o_refresh_req,
	input wire logic       o_speaker,
	input wire logic       i_parity_err,
	input wire logic       i_chan_check_n,
	input wire logic       o_nmi,
	input wire logic [2:0] i_dma_ch,
	input wire logic       i_dma_active,
	input wire logic       o_dma_ch_valid,
	input wire logic       i_fpu_busy_set,
	input wire logic       o_fpu_busy
);
	// one domain for every property
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	property p_board; (i_io_wr || i_io_rd) && i_io_addr <= 10'h0FF |-> o_io_board_sel && !o_io_chan_fwd; endproperty
	a_board: assert property (p_board) else $error("board i/o forwarded");
	property p_chan; (i_io_wr || i_io_rd) && i_io_addr >= 10'h100 |-> o_io_chan_fwd && !o_io_board_sel; endproperty
	a_chan: assert property (p_chan) else $error("channel i/o not forwarded");
	property p_gate2; i_io_wr && i_io_addr == 10'h061 |=> o_timer_gate2 == $past(i_io_wdata[0]); endproperty
	a_gate2: assert property (p_gate2) else $error("gate 2 not from port bit 0");
	property p_refresh; $rose(i_timer_out1) |-> o_refresh_req ##1 !o_refresh_req; endproperty
	a_refresh: assert property (p_refresh) else $error("refresh request not one pulse");
	property p_speaker; o_speaker == i_timer_out2; endproperty
	a_speaker: assert property (p_speaker) else $error("speaker not timer 2");
	property p_nmi; o_nmi == (i_parity_err || !i_chan_check_n); endproperty
	a_nmi: assert property (p_nmi) else $error("nmi wrong");
	property p_dma; o_dma_ch_valid == (i_dma_active && i_dma_ch != 3'h4); endproperty
	a_dma: assert property (p_dma) else $error("dma channel valid wrong");
	property p_fpu; i_io_wr && i_io_addr == 10'h0F0 && !i_fpu_busy_set |=> !o_fpu_busy; endproperty
	a_fpu: assert property (p_fpu) else $error("busy not cleared");
	// main scenarios seen
	c_gate: cover property (i_io_wr && i_io_addr == 10'h061 && i_io_wdata[0]);
	c_ref: cover property (o_refresh_req);
	c_fpu: cover property (o_fpu_busy ##1 !o_fpu_busy);
endmodule
bind atg_board_glue atg_board_checker atg_board_checker_i (.i_clk_sys, .i_rst, .i_io_addr, .i_io_wr, .i_io_rd,
	.i_io_wdata, .o_io_board_sel, .o_io_chan_fwd, .i_timer_out1, .i_timer_out2, .o_timer_gate2, .o_refresh_req,
	.o_speaker, .i_parity_err, .i_chan_check_n, .o_nmi, .i_dma_ch, .i_dma_active, .o_dma_ch_valid,
	.i_fpu_busy_set, .o_fpu_busy);

// ===== test/atg_far_model.sv
// Purpose: timers and adapter card beside the glue
// Assumes: timer counts on the system clock here
// Notes:   periods shortened to cycles
module atg_far_model #(
	parameter int P1 = 150,
	parameter int H2 = 20
) (
	// clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	// controls
	input  wire logic i_gate2,
	input  wire logic i_tick_en,
	input  wire logic i_card16,
	// outputs to the glue
	output logic      o_out0,
	output logic      o_out1,
	output logic      o_out2,
	output logic      o_cs16_n
);
	int c1;
	int c2;
	// refresh rate generator, one rise each period
	always_ff @(posedge i_clk_sys) begin
		c1 <= (i_rst || c1 == P1 - 1) ? 0 : c1 + 1;
		o_out1 <= c1 < P1 / 2;
	end
	// tone square wave, held high while gate is off
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || !i_gate2) begin
			c2 <= 0;
			o_out2 <= 1'b1;
		end else if (c2 == H2 - 1) begin
			c2 <= 0;
			o_out2 <= ~o_out2;
		end else
			c2 <= c2 + 1;
	end
	// system tick and card width
	assign o_out0 = i_tick_en & o_out1;
	assign o_cs16_n = ~i_card16;
endmodule

// ===== test/tb.sv
// Purpose: self-checking bench for the board glue
// Assumes: 100 ns clock, inputs moved at falling edge
// Notes:   timer periods shortened in the far model
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, wr = 0, rd = 0, mq = 0, sa = 0, ss = 0, card = 0, sec = 0, par = 0, chkn = 1;
	logic fset = 0, dact = 0, rcyc = 0, tick = 0, rv, bsel, cfwd, tsel, shs, mfwd, c16n, c16o, c8o, t0, t1, t2;
	logic g0, g1, g2, rreq, spk, any, nmi, fbusy, word, vld;
	logic [9:0] a = 0;
	logic [7:0] wd = 0, irqp = 0, rdat, pri, page;
	logic [23:0] ma = 0, caddr;
	logic [2:0] dch = 0, top;
	logic [1:0] tport;
	int errors = 0, checks = 0, cyc = 0;
	atg_board_glue atg_board_glue_i (.i_clk_sys(clk), .i_rst(rst), .i_io_addr(a), .i_io_wr(wr), .i_io_rd(rd),
		.i_io_wdata(wd), .o_io_rdata(rdat), .o_io_rvalid(rv), .i_mem_addr(ma), .i_mem_req(mq),
		.i_shadow_adrom(sa), .i_shadow_sysrom(ss), .o_io_board_sel(bsel), .o_io_chan_fwd(cfwd),
		.o_timer_sel(tsel), .o_timer_port(tport), .o_mem_shadow_sel(shs), .o_mem_chan_fwd(mfwd),
		.o_chan_addr(caddr), .i_card_cs16_n(c16n), .o_cycle_16(c16o), .o_cycle_8(c8o), .i_timer_out0(t0),
		.i_timer_out1(t1), .i_timer_out2(t2), .o_timer_gate0(g0), .o_timer_gate1(g1), .o_timer_gate2(g2),
		.o_refresh_req(rreq), .o_speaker(spk), .i_sec_int(sec), .i_irq_pri(irqp), .o_pri_irq(pri),
		.o_irq_top(top), .o_irq_any(any), .i_parity_err(par), .i_chan_check_n(chkn), .o_nmi(nmi),
		.i_fpu_busy_set(fset), .o_fpu_busy(fbusy), .i_dma_ch(dch), .i_dma_active(dact),
		.i_refresh_cycle(rcyc), .o_dma_page(page), .o_dma_word(word), .o_dma_ch_valid(vld));
	atg_far_model atg_far_model_i (.i_clk_sys(clk), .i_rst(rst), .i_gate2(g2), .i_tick_en(tick),
		.i_card16(card), .o_out0(t0), .o_out1(t1), .o_out2(t2), .o_cs16_n(c16n));
	// clock and hang guard
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			errors++;
			close_out;
		end
	end
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic iow(input logic [9:0] x, input logic [7:0] d);
		@(negedge clk);
		a = x;
		wd = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
	endtask
	task automatic ior(input logic [9:0] x, input logic v, input logic [7:0] d);
		@(negedge clk);
		a = x;
		rd = 1;
		@(negedge clk);
		rd = 0;
		chk(rv, v);
		chk(rdat, d);
	endtask
	task automatic tone(input int e);
		int n;
		logic l;
		n = 0;
		// let a gate change settle in the far model before counting
		repeat (2) @(negedge clk);
		l = spk;
		repeat (200) begin
			@(negedge clk);
			n += (spk !== l);
			l = spk;
		end
		chk(n, e);
	endtask
	task t_pages;
		logic [9:0] p [8] = '{10'h087, 10'h083, 10'h081, 10'h082, 10'h08B, 10'h089, 10'h08A, 10'h08F};
		for (int i = 0; i < 8; i++) begin
			ior(p[i], 1, 8'h00);
			iow(p[i], 8'hA0 + i);
			ior(p[i], 1, 8'hA0 + i);
		end
		ior(10'h090, 0, 8'h00);
		dact = 1;
		for (int i = 0; i < 8; i++) begin
			dch = i;
			#1 chk(vld, i != 4);
			chk(word, i > 4);
			if (i != 4) chk(page, 8'hA0 + i - (i > 4));
		end
		rcyc = 1;
		#1 chk(page, 8'hA7);
		rcyc = 0;
		dact = 0;
		$display("pages done");
	endtask
	task t_decode;
		logic [9:0] x [6] = '{10'h000, 10'h0FF, 10'h100, 10'h3FF, 10'h040, 10'h043};
		for (int i = 0; i < 6; i++) begin
			@(negedge clk);
			a = x[i];
			rd = 1;
			#1 chk(bsel, i < 2 || i > 3);
			chk(cfwd, i == 2 || i == 3);
			chk({tsel, tport}, {i > 3, x[i][1:0]});
		end
		@(negedge clk);
		rd = 0;
		$display("decode done");
	endtask
	task t_mem;
		logic [23:0] m [5] = '{24'h0C0000, 24'h0DFFFF, 24'h0E0000, 24'h0EFFFF, 24'h0BFFFF};
		logic [4:0] en = 5'b11010, sh = 5'b01010, fw = 5'b00001;
		mq = 1;
		for (int i = 0; i < 5; i++) begin
			ma = m[i];
			sa = en[i];
			ss = en[i];
			#1 chk({shs, mfwd}, {sh[i], fw[i]});
			chk(caddr, m[i]);
			for (int k = 0; k < 2 && i == 0; k++) begin
				card = k;
				#1 chk({c16o, c8o}, k ? 2'b10 : 2'b01);
			end
		end
		mq = 0;
		$display("memory done");
	endtask
	task t_timer;
		int n;
		iow(10'h061, 8'h01);
		ior(10'h061, 1, 8'h01);
		chk({g0, g1, g2}, 3'b111);
		tone(10);
		iow(10'h061, 8'h00);
		tone(0);
		n = 0;
		repeat (1500) begin
			@(negedge clk);
			n += rreq;
		end
		chk(n, 10);
		irqp = 8'hFA;
		#1 chk(top, 1);
		irqp = 8'hF8;
		#1 chk({any, top}, 4'hB);
		sec = 1;
		#1 chk({pri[2], top}, 4'hA);
		tick = 1;
		for (n = 0; !t0 && n < 200; n++) @(negedge clk);
		#1 chk({pri[0], top}, 4'h8);
		tick = 0;
		sec = 0;
		irqp = 0;
		@(negedge clk);
		chk(any, 0);
		for (int k = 0; k < 4; k++) begin
			{chkn, par} = k;
			#1 chk(nmi, k != 2);
		end
		chkn = 1;
		par = 0;
		fset = 1;
		iow(10'h0F0, 8'h00);
		fset = 0;
		chk(fbusy, 1);
		iow(10'h0F0, 8'h00);
		chk(fbusy, 0);
		$display("timer done");
	endtask
	task close_out;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// reset then scenarios
	initial begin
		repeat (16) @(negedge clk);
		rst = 0;
		t_pages;
		t_decode;
		t_mem;
		t_timer;
		close_out;
	end
endmodule
